// File: rtl/cmlh_fifo.sv
module cmlh_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 8
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [WIDTH-1:0] wr_data_in,
	input wire logic wr_valid_in,
	output logic wr_ready_out,
	output logic [WIDTH-1:0] rd_data_out,
	output logic rd_valid_out,
	input wire logic rd_ready_in
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0] cnt_r;
	logic push;
	logic pop;

	// ****************************************
	// Handshake
	// ****************************************
	assign wr_ready_out = (cnt_r != (AW+1)'(DEPTH));
	assign rd_valid_out = (cnt_r != '0);
	assign push = wr_valid_in && wr_ready_out;
	assign pop = rd_valid_out && rd_ready_in;
	assign rd_data_out = mem[rp_r];

	// Storage
	always_ff @(posedge clk_in)
	begin
		if (push)
			mem[wp_r] <= wr_data_in;
	end

	// Pointers and fill count
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end
		else
		begin
			if (push)
				wp_r <= wp_r + 1'b1;
			if (pop)
				rp_r <= rp_r + 1'b1;
			if (push && !pop)
				cnt_r <= cnt_r + 1'b1;
			else if (pop && !push)
				cnt_r <= cnt_r - 1'b1;
		end
	end
endmodule // cmlh_fifo

// File: rtl/cmlh_host.sv
// What this block does
// - Frame syncs and serial clock are inputs.
// - Every word is sixteen bits wide.
// - Two frames per interval: control, then data.
// - Role strap sampled after reset release.
// - Half clock select latched to half_clock_out after reset release.
module cmlh_host (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic host_serial_clock_in,
	input wire logic host_transmit_sync_in,
	input wire logic host_receive_sync_in,
	input wire logic serial_data_in,
	input wire logic role_select_strap_in,
	input wire logic half_clock_select_in,
	output logic serial_data_out,
	output logic role_master_out,
	output logic half_clock_out,
	output logic [15:0] status_word_out,
	output logic status_valid_out,
	output logic [15:0] dac_word_out
);
	logic [2:0] sck_s_r, tfs_s_r, rfs_s_r, din_s_r;
	logic sck_q_r, tfs_q_r, rfs_q_r, din_q_r;
	logic sck_rise, sck_fall, tfs_now;
	logic [15:0] transmit_holding_reg, tx_shift_r;
	logic [3:0] tx_bit_r, rx_bit_r;
	logic tx_busy_r, tx_load_pend_r, tx_event, tx_slot_r;
	logic [15:0] rx_shift_r, receive_holding_reg;
	logic rx_busy_r, rx_event_r, is_adc;
	logic [1:0] rx_count_r;
	logic [2:0] ctrl_idx_r;
	cmlh_pkg::cmlh_txbuf_t txbuf_r;
	logic strap_done_r, status_valid_r, f_rd_valid;
	logic [15:0] f_rd_data;

	// Agree check for three-stage synchroniser
	function automatic logic agree(input logic [2:0] s, input logic q);
		agree = (s[2] == s[1]) ? s[1] : q;
	endfunction

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// All link input pins (clock, syncs, data in) are filtered before use
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			sck_s_r <= 3'h0;
			tfs_s_r <= 3'h0;
			rfs_s_r <= 3'h0;
			din_s_r <= 3'h0;
			sck_q_r <= 1'b0;
			tfs_q_r <= 1'b0;
			rfs_q_r <= 1'b0;
			din_q_r <= 1'b0;
		end
		else
		begin
			sck_s_r <= {sck_s_r[1:0], host_serial_clock_in};
			tfs_s_r <= {tfs_s_r[1:0], host_transmit_sync_in};
			rfs_s_r <= {rfs_s_r[1:0], host_receive_sync_in};
			din_s_r <= {din_s_r[1:0], serial_data_in};
			sck_q_r <= agree(sck_s_r, sck_q_r);
			tfs_q_r <= agree(tfs_s_r, tfs_q_r);
			rfs_q_r <= agree(rfs_s_r, rfs_q_r);
			din_q_r <= agree(din_s_r, din_q_r);
		end
	end

	// Edges of the filtered serial clock
	assign sck_rise = agree(sck_s_r, sck_q_r) && !sck_q_r;
	assign sck_fall = !agree(sck_s_r, sck_q_r) && sck_q_r;
	assign tfs_now = agree(tfs_s_r, tfs_q_r); // Sync in step with edges

	// Role and clock reference caught once after release
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			strap_done_r <= 1'b0;
			role_master_out <= 1'b0;
			half_clock_out <= 1'b0;
		end
		else if (!strap_done_r)
		begin
			strap_done_r <= 1'b1;
			role_master_out <= role_select_strap_in;
			half_clock_out <= half_clock_select_in;
		end
	end

	// ****************************************
	// Transmit path
	// ****************************************
	// Event while second bit goes out
	assign tx_event = sck_rise && tx_busy_r &&
		(tx_bit_r == cmlh_pkg::TX_EVENT_BIT);

	// Shifter, driven on rising clock, one bit per clock
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			tx_shift_r <= cmlh_pkg::WORD_RST;
			tx_bit_r <= cmlh_pkg::BIT_CNT_RST;
			tx_busy_r <= 1'b0;
			serial_data_out <= 1'b0; // Low through reset
		end
		else if (sck_rise)
		begin
			if (tx_busy_r && tx_bit_r != cmlh_pkg::LAST_BIT)
			begin
				serial_data_out <= tx_shift_r[15];
				tx_shift_r <= {tx_shift_r[14:0], 1'b0};
				tx_bit_r <= tx_bit_r + 4'h1;
			end
			else if (tfs_now) // Prior word finished first
			begin
				serial_data_out <= transmit_holding_reg[15];
				tx_shift_r <= {transmit_holding_reg[14:0], 1'b0};
				tx_bit_r <= cmlh_pkg::BIT_CNT_RST;
				tx_busy_r <= 1'b1;
			end
			else
			begin
				tx_busy_r <= 1'b0;
				serial_data_out <= 1'b0;
			end
		end
	end

	// Holding register refilled from alternating slot
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			transmit_holding_reg <= cmlh_pkg::CTRL_SEQ[0];
			tx_slot_r <= 1'b1;
			tx_load_pend_r <= 1'b0;
		end
		else if (tx_event)
		begin
			transmit_holding_reg <= tx_slot_r ? txbuf_r.dac : txbuf_r.ctrl;
			tx_slot_r <= !tx_slot_r;
			tx_load_pend_r <= 1'b1;
		end
		else
			tx_load_pend_r <= 1'b0;
	end

	// ****************************************
	// Receive path
	// ****************************************
	// Sample on falling clock, frame opens on sync
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			rx_shift_r <= cmlh_pkg::WORD_RST;
			rx_bit_r <= cmlh_pkg::BIT_CNT_RST;
			rx_busy_r <= 1'b0;
			receive_holding_reg <= cmlh_pkg::WORD_RST;
			rx_event_r <= 1'b0;
		end
		else
		begin
			rx_event_r <= 1'b0;
			if (sck_fall && (rx_busy_r || rfs_q_r))
			begin
				rx_shift_r <= {rx_shift_r[14:0], din_q_r};
				rx_bit_r <= rx_busy_r ? rx_bit_r + 4'h1 : 4'h1;
				rx_busy_r <= 1'b1;
				if (rx_busy_r && rx_bit_r == cmlh_pkg::LAST_BIT)
				begin
					// Event only once whole word held
					receive_holding_reg <= {rx_shift_r[14:0], din_q_r};
					rx_event_r <= 1'b1;
					rx_busy_r <= 1'b0;
				end
			end
		end
	end

	// ****************************************
	// Interval sequencer
	// ****************************************
	assign is_adc = (rx_count_r == 2'h1);
	// Count receives; second one loops back
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			rx_count_r <= cmlh_pkg::RX_COUNT_RELOAD;
			ctrl_idx_r <= cmlh_pkg::CTRL_IDX_RST;
			txbuf_r <= '{ctrl: cmlh_pkg::CTRL_SEQ[0], dac: cmlh_pkg::WORD_RST};
		end
		else if (rx_event_r)
		begin
			if (!is_adc)
				rx_count_r <= rx_count_r - 2'h1;
			else
			begin
				rx_count_r <= cmlh_pkg::RX_COUNT_RELOAD;
				txbuf_r.dac <= receive_holding_reg;
				txbuf_r.ctrl <= cmlh_pkg::CTRL_SEQ[ctrl_idx_r];
				if (ctrl_idx_r != cmlh_pkg::CTRL_IDX_LAST)
					ctrl_idx_r <= ctrl_idx_r + 3'h1;
			end
		end
	end
	// Status words queued for the user side
	cmlh_fifo #(
		.WIDTH(cmlh_pkg::WORD_W),
		.DEPTH(cmlh_pkg::FIFO_DEPTH)
	) u_status_fifo (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.wr_data_in(receive_holding_reg),
		.wr_valid_in(rx_event_r && !is_adc),
		.wr_ready_out(),
		.rd_data_out(f_rd_data),
		.rd_valid_out(f_rd_valid),
		.rd_ready_in(1'b1)
	);
	// Drained every cycle into the output register, so it never fills
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			status_word_out <= cmlh_pkg::WORD_RST;
			status_valid_r <= 1'b0;
		end
		else
		begin
			status_valid_r <= f_rd_valid;
			if (f_rd_valid)
				status_word_out <= f_rd_data;
		end
	end
	assign status_valid_out = status_valid_r;
	assign dac_word_out = txbuf_r.dac;
	// ****************************************
	// Assertions
	// ****************************************
	property p_tx_event;
		@(posedge clk_in) disable iff (rst_in)
		tx_event |=> tx_load_pend_r && (tx_bit_r == 4'h1);
	endproperty
	a_tx_event: assert property (p_tx_event)
		else $error("transmit event not on second bit");
	property p_rx_loop;
		@(posedge clk_in) disable iff (rst_in)
		(rx_event_r && is_adc) |=>
			(txbuf_r.dac == $past(receive_holding_reg)) &&
			(rx_count_r == 2'h2);
	endproperty
	a_rx_loop: assert property (p_rx_loop)
		else $error("loopback or counter reload failed");
	property p_rx_count;
		@(posedge clk_in) disable iff (rst_in)
		(rx_event_r && !is_adc) |=> rx_count_r == 2'h1;
	endproperty
	a_rx_count: assert property (p_rx_count)
		else $error("receive counter did not decrement");
	property p_rx_event;
		@(posedge clk_in) disable iff (rst_in)
		rx_event_r |-> $past(rx_bit_r) == 4'hf;
	endproperty
	a_rx_event: assert property (p_rx_event)
		else $error("receive event before full word");
	property p_din_reset;
		@(posedge clk_in) rst_in |-> !serial_data_out;
	endproperty
	a_din_reset: assert property (p_din_reset)
		else $error("serial data not low in reset");
	property p_tx_steady;
		@(posedge clk_in) disable iff (rst_in)
		!sck_rise |=> $stable(serial_data_out);
	endproperty
	a_tx_steady: assert property (p_tx_steady)
		else $error("data moved without clock edge");
endmodule // cmlh_host

// File: rtl/cmlh_pkg.sv
package cmlh_pkg;
	// ****************************************
	// Word and sequencing constants
	// ****************************************
	localparam int WORD_W = 16;
	localparam logic [3:0] BIT_CNT_RST = 4'h0;
	localparam logic [3:0] LAST_BIT = 4'hf;
	localparam logic [3:0] TX_EVENT_BIT = 4'h0; // Count as second bit leaves
	localparam logic [1:0] RX_COUNT_RELOAD = 2'h2;
	localparam int CTRL_WORDS = 7;
	localparam logic [2:0] CTRL_IDX_LAST = 3'h6;
	localparam logic [2:0] CTRL_IDX_RST = 3'h1;
	localparam logic [15:0] WORD_RST = 16'h0000;
	localparam int FIFO_DEPTH = 8;
	// Control words sent one per sample interval
	localparam logic [15:0] CTRL_SEQ [CTRL_WORDS] = '{
		16'h807c, 16'h8a00, 16'h9000, 16'h9809,
		16'ha000, 16'ha800, 16'h3000};

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed
	{
		logic [WORD_W-1:0] ctrl;
		logic [WORD_W-1:0] dac;
	} cmlh_txbuf_t;

	typedef struct packed
	{
		logic [WORD_W-1:0] status;
		logic [WORD_W-1:0] adc;
	} cmlh_rxbuf_t;
endpackage // cmlh_pkg

// File: verification/cmlh_codec_model.sv
// ****************************************
// Codec acting as serial frame master
// ****************************************
module cmlh_codec_model #(
	parameter int HALF = 8
) (
	input wire logic clk_in,
	output logic bit_clock_out,
	output logic frame_sync_out,
	output logic data_out,
	input wire logic data_in
);
	timeunit 1ns;
	timeprecision 100ps;

	// Clock parked low and no sync outside frames
	initial
	begin
		bit_clock_out = 1'b0;
		frame_sync_out = 1'b0;
		data_out = 1'b0;
	end

	// One frame of 16 bits, MSB first; bad adds a stray sync
	task automatic frame(input logic [15:0] w, input int bad,
		output logic [15:0] got);
		for (int i = 0; i < 16; i++)
		begin
			frame_sync_out = (i == 0) || (i == bad);
			bit_clock_out = 1'b1;
			data_out = w[15-i];
			repeat (HALF) @(negedge clk_in);
			bit_clock_out = 1'b0;
			got[15-i] = data_in;
			repeat (HALF) @(negedge clk_in);
		end
		frame_sync_out = 1'b0;
		data_out = ~w[0]; // Released line shows no stale bit
	endtask

	// Control/status frame, then DAC/ADC frame
	task automatic interval(input logic [15:0] status, adc,
		input int bad, output logic [15:0] ctrl, dac);
		frame(status, bad, ctrl);
		frame(adc, -1, dac);
		repeat (2 * HALF) @(negedge clk_in);
	endtask
endmodule // cmlh_codec_model

// File: verification/cmlh_host_bench.sv
module cmlh_host_bench;
	timeunit 1ns;
	timeprecision 100ps;

	// ****************************************
	// Signals and instances
	// ****************************************
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic role_in = 1'b1;
	logic half_in = 1'b0;
	logic sclk, fsync, cdata, sdo, role_m, half_c, svalid, sv_d;
	logic [15:0] sword, dword;
	logic [15:0] ctrl_q [$];
	int fails = 0;
	int n_tests = 0;
	int pulses = 0;

	// Free-running system clock
	always #5 clk_in = ~clk_in;

	cmlh_codec_model codec (
		.clk_in(clk_in),
		.bit_clock_out(sclk),
		.frame_sync_out(fsync),
		.data_out(cdata),
		.data_in(sdo)
	);

	cmlh_host DUT (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.host_serial_clock_in(sclk),
		.host_transmit_sync_in(fsync),
		.host_receive_sync_in(fsync),
		.serial_data_in(cdata),
		.role_select_strap_in(role_in),
		.half_clock_select_in(half_in),
		.serial_data_out(sdo),
		.role_master_out(role_m),
		.half_clock_out(half_c),
		.status_word_out(sword),
		.status_valid_out(svalid),
		.dac_word_out(dword)
	);

	// Counts status pulses, sampled away from the launching edge
	always @(negedge clk_in)
	begin
		if (svalid === 1'b1 && sv_d !== 1'b1)
			pulses++;
		sv_d <= svalid;
	end

	// ****************************************
	// Shared tasks
	// ****************************************
	task check(input logic [15:0] got, exp);
		n_tests++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got,
				exp);
		end
	endtask

	task stop_test;
		if (fails == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// Reset with given straps, check outputs held and straps caught
	task do_reset(input logic role, half);
		@(negedge clk_in);
		rst_in = 1'b1;
		role_in = role;
		half_in = half;
		repeat (8) @(negedge clk_in);
		check({15'h0, sdo}, 16'h0000);
		check(dword, 16'h0000);
		rst_in = 1'b0;
		repeat (3) @(negedge clk_in);
		check({15'h0, role_m}, {15'h0, role});
		check({15'h0, half_c}, {15'h0, half});
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task t_straps;
		do_reset(1'b0, 1'b1);
		do_reset(1'b1, 1'b0);
	endtask

	// Twelve intervals of loopback, stray sync in interval 4
	task t_loopback;
		logic [15:0] c, d;
		int j;
		do_reset(1'b1, 1'b1);
		for (int k = 0; k < 12; k++)
		begin
			pulses = 0;
			codec.interval(16'h5a00 + 16'(k), 16'h1200 + 16'(k),
				(k == 4) ? 8 : -1, c, d);
			ctrl_q.push_back(c);
			check(sword, 16'h5a00 + 16'(k));
			check(16'(pulses), 16'h0001);
			check(dword, 16'h1200 + 16'(k));
			if (k > 0)
				check(d, 16'h1200 + 16'(k - 1));
		end
		check(ctrl_q[0], 16'h807c);
		j = 0;
		for (int i = 11; i > 0; i--)
			if (ctrl_q[i] === 16'h8a00)
				j = i;
		check(16'(j > 0 && j < 6), 16'h0001);
		if (j > 0 && j < 6)
		begin
			check(ctrl_q[j-1], 16'h807c);
			for (int i = 1; i < 12 - j + 1; i++)
				check(ctrl_q[j+i-1],
					cmlh_pkg::CTRL_SEQ[(i > 6) ? 6 : i]);
		end
	endtask

	// ****************************************
	// Main sequence and watchdog
	// ****************************************
	initial
	begin
		t_straps;
		t_loopback;
		stop_test;
	end

	initial
	begin
		#200000;
		fails++;
		stop_test;
	end
endmodule // cmlh_host_bench
